// ===== rtl/pcera_pkg.sv
// Package for the root port configuration access bridge.
// Holds address field layout, bus map constants, types shared by the bridge files.
package pcera_pkg;

  localparam int unsigned REG_LSB      = 2;
  localparam int unsigned REG_MSB      = 7;
  localparam int unsigned EXT_LSB      = 8;
  localparam int unsigned EXT_MSB      = 11;
  localparam int unsigned FUNC_LSB     = 12;
  localparam int unsigned FUNC_MSB     = 14;
  localparam int unsigned DEV_LSB      = 15;
  localparam int unsigned DEV_MSB      = 19;
  localparam int unsigned BUS_LSB      = 20;
  localparam int unsigned APERTURE_EXP = 20;
  localparam int unsigned BUS_MAX_W    = 8;
  localparam logic [7:0]  PRIMARY_BUS_RST = 8'h00;
  localparam logic [7:0]  SECONDARY_BUS_RST = 8'h00;
  localparam logic [7:0]  SUBORDINATE_BUS_RST = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Routing decision for one access.
  typedef enum logic [1:0] {
    PCERA_ROUTE_LOCAL,
    PCERA_ROUTE_TYPE0,
    PCERA_ROUTE_TYPE1,
    PCERA_ROUTE_ERROR
  } pcera_route_t;

  // Decoded configuration address.
  typedef struct packed {
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
    logic [3:0] ext_reg;
    logic [5:0] reg_num;
  } pcera_cfg_addr_t;

  // Configuration request towards the link.
  typedef struct packed {
    pcera_cfg_addr_t addr;
    logic            cfg_type1;
    logic            write;
    logic [3:0]      byte_en;
    logic [31:0]     data;
  } pcera_cfg_req_t;

  // Configuration completion from the link.
  typedef struct packed {
    logic        ok;
    logic [31:0] data;
  } pcera_cfg_cpl_t;

endpackage

// ===== rtl/pcera_decode.sv
// Address field decoder and bus routing for configuration accesses.
// Assumes the bus numbers come from registered header fields on the same clock.
`timescale 1ns/1ns
module pcera_decode
  import pcera_pkg::*;
#(
  parameter int unsigned BUS_W = 8
)
(
  // Access address and bus map.
  input  wire logic [31:0]     addr_i,
  input  wire logic [7:0]      primary_bus_i,
  input  wire logic [7:0]      secondary_bus_i,
  input  wire logic [7:0]      subordinate_bus_i,
  // Result.
  output pcera_cfg_addr_t      cfg_addr_o,
  output pcera_route_t         route_o
);

  logic [7:0] bus;

  // Bits above the aperture width do not belong to the bus number.
  always_comb
  begin
    bus                = '0;
    bus[BUS_W-1:0]     = addr_i[BUS_LSB +: BUS_W];
    cfg_addr_o.bus     = bus;
    cfg_addr_o.dev     = addr_i[DEV_MSB:DEV_LSB];
    cfg_addr_o.func    = addr_i[FUNC_MSB:FUNC_LSB];
    cfg_addr_o.ext_reg = addr_i[EXT_MSB:EXT_LSB];
    cfg_addr_o.reg_num = addr_i[REG_MSB:REG_LSB];
  end

  always_comb
  begin
    if (bus == primary_bus_i)
      route_o = PCERA_ROUTE_LOCAL;
    else if (bus == secondary_bus_i)
      route_o = PCERA_ROUTE_TYPE0;
    else if (bus > secondary_bus_i && bus <= subordinate_bus_i)
      route_o = PCERA_ROUTE_TYPE1;
    else
      route_o = PCERA_ROUTE_ERROR;
  end

endmodule // pcera_decode

// ===== rtl/pcera_bridge.sv
// Root port configuration access bridge: AXI4-Lite slave to config requests.
// Assumes one clock, a synchronous active-low reset and a link side on the same clock.
`timescale 1ns/1ns
module pcera_bridge
  import pcera_pkg::*;
#(
  parameter bit          ROOT_PORT_ENABLE     = 1'b1,
  parameter logic [31:0] CONTROL_BASE_ADDRESS = 32'h0000_0000,
  parameter logic [31:0] CONTROL_HIGH_ADDRESS = 32'h0fff_ffff,
  parameter logic [11:0] AER_CAP_BASE         = 12'h100,
  parameter logic [11:0] AER_CAP_LAST         = 12'h137
)
(
  // Clock and reset.
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // AXI4-Lite write address, data and response.
  input  wire logic [31:0]     s_axi_awaddr_i,
  input  wire logic            s_axi_awvalid_i,
  output logic                 s_axi_awready_o,
  input  wire logic [31:0]     s_axi_wdata_i,
  input  wire logic [3:0]      s_axi_wstrb_i,
  input  wire logic            s_axi_wvalid_i,
  output logic                 s_axi_wready_o,
  output logic [1:0]           s_axi_bresp_o,
  output logic                 s_axi_bvalid_o,
  input  wire logic            s_axi_bready_i,
  // AXI4-Lite read.
  input  wire logic [31:0]     s_axi_araddr_i,
  input  wire logic            s_axi_arvalid_i,
  output logic                 s_axi_arready_o,
  output logic [31:0]          s_axi_rdata_o,
  output logic [1:0]           s_axi_rresp_o,
  output logic                 s_axi_rvalid_o,
  input  wire logic            s_axi_rready_i,
  // Link configuration request and completion.
  output pcera_cfg_req_t       cfg_req_o,
  output logic                 cfg_req_valid_o,
  input  wire logic            cfg_req_ready_i,
  input  pcera_cfg_cpl_t       cfg_cpl_i,
  input  wire logic            cfg_cpl_valid_i,
  // Local header port, any device and function of the primary bus and any access outside the aperture, except dwords in the AER capability range.
  output logic                 local_en_o,
  output logic                 local_we_o,
  output logic [9:0]           local_index_o,
  output logic [3:0]           local_be_o,
  output logic [31:0]          local_wdata_o,
  input  wire logic [31:0]     local_rdata_i,
  // Requester read hold and abnormal termination event.
  output logic                 req_read_hold_o,
  output logic                 cfg_abort_pulse_o,
  // Bus numbers held in the local header.
  output logic [7:0]           primary_bus_o,
  output logic [7:0]           secondary_bus_o,
  output logic [7:0]           subordinate_bus_o
);

  // Number of low-order bits up to and including the highest bit where base and high differ.
  function automatic int unsigned diff_bits();
    int unsigned n;
    n = 0;
    for (int i = 0; i < 32; i++)
    begin
      if (CONTROL_BASE_ADDRESS[i] != CONTROL_HIGH_ADDRESS[i])
        n = i + 1;
    end
    return n;
  endfunction

  localparam int unsigned RAW_BITS = diff_bits();
  localparam int unsigned RAW_SIZE =
    (RAW_BITS > APERTURE_EXP) ? RAW_BITS - APERTURE_EXP : 1;
  localparam int unsigned CONFIG_APERTURE_SIZE = ROOT_PORT_ENABLE ?
    ((RAW_SIZE > BUS_MAX_W) ? BUS_MAX_W : RAW_SIZE) : 0;
  localparam int unsigned BUS_W = (CONFIG_APERTURE_SIZE == 0) ? 1 : CONFIG_APERTURE_SIZE;
  localparam int unsigned APERTURE_BITS = APERTURE_EXP + BUS_W;

  // Header dword that carries the three bus numbers.
  localparam logic [9:0]  BUS_NUM_DWORD = 10'h006;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_LOCAL,
    ST_LINK_REQ,
    ST_LINK_WAIT,
    ST_RESP
  } pcera_state_t;

  pcera_state_t     state_q;
  logic             is_write_q;
  logic [31:0]      addr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       be_q;
  logic [1:0]       resp_q;
  logic [31:0]      rdata_q;
  logic             aw_seen_q;
  logic             w_seen_q;
  pcera_cfg_addr_t  cfg_addr;
  pcera_route_t     route;
  logic             in_aperture;
  logic             aer_hit;
  logic [9:0]       dword_index;

  pcera_decode #(
    .BUS_W            (BUS_W)
  ) u_decode (
    .addr_i           (addr_q),
    .primary_bus_i    (primary_bus_o),
    .secondary_bus_i  (secondary_bus_o),
    .subordinate_bus_i(subordinate_bus_o),
    .cfg_addr_o       (cfg_addr),
    .route_o          (route)
  );

  assign in_aperture = ((addr_q - CONTROL_BASE_ADDRESS) >> APERTURE_BITS) == 32'h0;
  assign dword_index = {cfg_addr.ext_reg, cfg_addr.reg_num};
  assign aer_hit     = ({dword_index, 2'b00} >= AER_CAP_BASE) &&
                       ({dword_index, 2'b00} <= AER_CAP_LAST);

  // Write address and data may arrive in either order; both are caught first.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_seen_q <= 1'b0;
      w_seen_q  <= 1'b0;
    end
    else if (state_q == ST_IDLE)
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
        aw_seen_q <= 1'b1;
      if (s_axi_wvalid_i && s_axi_wready_o)
        w_seen_q <= 1'b1;
    end
    else if (state_q == ST_DECODE)
    begin
      aw_seen_q <= 1'b0;
      w_seen_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end
    else
    begin
      // Reads get priority in idle; one access is open at a time.
      // Ready only rises on a pending valid, so a read and a write are never taken together.
      s_axi_arready_o <= state_q == ST_IDLE && !aw_seen_q && !w_seen_q && s_axi_arvalid_i &&
                         !s_axi_arready_o && !s_axi_awready_o && !s_axi_wready_o;
      s_axi_awready_o <= state_q == ST_IDLE && !aw_seen_q && s_axi_awvalid_i &&
                         (w_seen_q || !s_axi_arvalid_i) &&
                         !s_axi_awready_o && !s_axi_arready_o;
      s_axi_wready_o  <= state_q == ST_IDLE && !w_seen_q && s_axi_wvalid_i &&
                         (aw_seen_q || !s_axi_arvalid_i) &&
                         !s_axi_wready_o && !s_axi_arready_o;
    end
  end

  // Capture of the access.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      is_write_q <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= '0;
      be_q       <= '0;
    end
    else if (state_q == ST_IDLE)
    begin
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        is_write_q <= 1'b0;
        addr_q     <= s_axi_araddr_i;
        be_q       <= 4'hf;
      end
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        is_write_q <= 1'b1;
        addr_q     <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        wdata_q <= s_axi_wdata_i;
        be_q    <= s_axi_wstrb_i;
      end
    end
  end

  // Main sequence.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if ((s_axi_arvalid_i && s_axi_arready_o) ||
              ((aw_seen_q || (s_axi_awvalid_i && s_axi_awready_o)) &&
               (w_seen_q || (s_axi_wvalid_i && s_axi_wready_o))))
            state_q <= ST_DECODE;
        ST_DECODE:
          if (!ROOT_PORT_ENABLE || !in_aperture || route == PCERA_ROUTE_LOCAL)
            state_q <= ST_LOCAL;
          else if (route == PCERA_ROUTE_ERROR)
            state_q <= ST_RESP;
          else
            state_q <= ST_LINK_REQ;
        ST_LOCAL:
          state_q <= ST_RESP;
        ST_LINK_REQ:
          if (cfg_req_ready_i)
            state_q <= ST_LINK_WAIT;
        ST_LINK_WAIT:
          if (cfg_cpl_valid_i)
            state_q <= ST_RESP;
        ST_RESP:
          if ((s_axi_bvalid_o && s_axi_bready_i) || (s_axi_rvalid_o && s_axi_rready_i))
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Answer collection.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      resp_q  <= RESP_OKAY;
      rdata_q <= '0;
    end
    else if (state_q == ST_DECODE)
    begin
      resp_q  <= (ROOT_PORT_ENABLE && in_aperture && route == PCERA_ROUTE_ERROR) ?
                 RESP_SLVERR : RESP_OKAY;
      rdata_q <= '0;
    end
    else if (state_q == ST_LOCAL)
      rdata_q <= aer_hit ? 32'h0 : local_rdata_i;
    else if (state_q == ST_LINK_WAIT && cfg_cpl_valid_i)
    begin
      resp_q  <= cfg_cpl_i.ok ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= cfg_cpl_i.data;
    end
  end

  // Local header access; device and function fields are ignored.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      local_en_o    <= 1'b0;
      local_we_o    <= 1'b0;
      local_index_o <= '0;
      local_be_o    <= '0;
      local_wdata_o <= '0;
    end
    else
    begin
      local_en_o    <= state_q == ST_DECODE && !aer_hit &&
                       (!ROOT_PORT_ENABLE || !in_aperture || route == PCERA_ROUTE_LOCAL);
      local_we_o    <= is_write_q;
      local_index_o <= dword_index;
      local_be_o    <= be_q;
      local_wdata_o <= wdata_q;
    end
  end

  // Bus numbers are snooped from writes to the local header.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      primary_bus_o     <= PRIMARY_BUS_RST;
      secondary_bus_o   <= SECONDARY_BUS_RST;
      subordinate_bus_o <= SUBORDINATE_BUS_RST;
    end
    else if (local_en_o && local_we_o && local_index_o == BUS_NUM_DWORD)
    begin
      if (local_be_o[0])
        primary_bus_o <= local_wdata_o[7:0];
      if (local_be_o[1])
        secondary_bus_o <= local_wdata_o[15:8];
      if (local_be_o[2])
        subordinate_bus_o <= local_wdata_o[23:16];
    end
  end

  // Link request; the control port stays stalled until completion.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cfg_req_o       <= '0;
      cfg_req_valid_o <= 1'b0;
    end
    else if (state_q == ST_DECODE)
    begin
      cfg_req_o.addr      <= cfg_addr;
      cfg_req_o.cfg_type1 <= route == PCERA_ROUTE_TYPE1;
      cfg_req_o.write     <= is_write_q;
      cfg_req_o.byte_en   <= be_q;
      cfg_req_o.data      <= wdata_q;
      cfg_req_valid_o     <= ROOT_PORT_ENABLE && in_aperture &&
                             (route == PCERA_ROUTE_TYPE0 || route == PCERA_ROUTE_TYPE1);
    end
    else if (cfg_req_valid_o && cfg_req_ready_i)
      cfg_req_valid_o <= 1'b0;
  end

  // Hold later requester reads while a config read is open; flag aborts.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      req_read_hold_o   <= 1'b0;
      cfg_abort_pulse_o <= 1'b0;
    end
    else
    begin
      if (state_q == ST_LINK_REQ && cfg_req_ready_i && !is_write_q)
        req_read_hold_o <= 1'b1;
      else if (state_q == ST_LINK_WAIT && cfg_cpl_valid_i)
        req_read_hold_o <= 1'b0;
      cfg_abort_pulse_o <= state_q == ST_LINK_WAIT && cfg_cpl_valid_i &&
                           !cfg_cpl_i.ok;
    end
  end

  // Response channels.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= RESP_OKAY;
      s_axi_rdata_o  <= '0;
    end
    else
    begin
      if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      else if (state_q == ST_RESP && is_write_q && !s_axi_bvalid_o)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= resp_q;
      end
      if (s_axi_rvalid_o && s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
      else if (state_q == ST_RESP && !is_write_q && !s_axi_rvalid_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= resp_q;
        s_axi_rdata_o  <= rdata_q;
      end
    end
  end

endmodule // pcera_bridge

// ===== bench/pcera_bridge_asserts.sv
// Port checks for the configuration bridge, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module pcera_bridge_asserts
  import pcera_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Host responses.
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic [31:0] s_axi_rdata_o,
  // Link side and bus map.
  input pcera_cfg_req_t   cfg_req_o,
  input wire logic        cfg_req_valid_o,
  input wire logic        cfg_req_ready_i,
  input pcera_cfg_cpl_t   cfg_cpl_i,
  input wire logic        cfg_cpl_valid_i,
  input wire logic        req_read_hold_o,
  input wire logic        cfg_abort_pulse_o,
  input wire logic [7:0]  primary_bus_o,
  input wire logic [7:0]  secondary_bus_o,
  input wire logic [7:0]  subordinate_bus_o
);
  logic [31:0] cpl_data_q;

  // Keeps the last completion dword so a read answer can be traced back to it.
  always_ff @(posedge clk_i)
  begin
    if (cfg_cpl_valid_i)
      cpl_data_q <= cfg_cpl_i.data;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fail_cpl;
    cfg_cpl_valid_i && !cfg_cpl_i.ok;
  endsequence
  sequence s_err_answer;
    (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR) || (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
  endsequence

  a_map_reset: assert property ($rose(rst_n_i) |-> {primary_bus_o, secondary_bus_o, subordinate_bus_o} == 24'h0)
    else $error("bus map not cleared by reset");
  a_req_route: assert property (cfg_req_valid_o |-> cfg_req_o.addr.bus != primary_bus_o
    && cfg_req_o.addr.bus >= secondary_bus_o && cfg_req_o.addr.bus <= subordinate_bus_o
    && cfg_req_o.cfg_type1 == (cfg_req_o.addr.bus != secondary_bus_o))
    else $error("request outside the bus map or wrong type");
  a_read_be: assert property (cfg_req_valid_o && !cfg_req_o.write |-> cfg_req_o.byte_en == 4'hf)
    else $error("read request without all byte enables");
  a_req_stands: assert property (cfg_req_valid_o && !cfg_req_ready_i |=> cfg_req_valid_o && $stable(cfg_req_o))
    else $error("request dropped or changed before ready");
  a_rvalid_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped before ready");
  a_bvalid_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped before ready");
  a_abort_event: assert property (s_fail_cpl |-> ##[1:2] cfg_abort_pulse_o ##1 !cfg_abort_pulse_o)
    else $error("failed completion without a one-cycle abort pulse");
  a_fail_slverr: assert property (s_fail_cpl |-> ##[1:4] s_err_answer)
    else $error("failed completion not answered with SLVERR");
  a_read_data: assert property (cfg_cpl_valid_i && cfg_cpl_i.ok && req_read_hold_o |-> ##[1:4]
    (s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY && s_axi_rdata_o == cpl_data_q))
    else $error("completion data not returned with OKAY");
  a_hold_read: assert property (cfg_req_valid_o && cfg_req_ready_i && !cfg_req_o.write |=>
    (req_read_hold_o until cfg_cpl_valid_i))
    else $error("read hold missing while a read is outstanding");
  a_hold_ends: assert property (req_read_hold_o |-> ##[0:40] !req_read_hold_o)
    else $error("read hold never released");
endmodule // pcera_bridge_asserts

bind pcera_bridge pcera_bridge_asserts u_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rdata_o(s_axi_rdata_o), .cfg_req_o(cfg_req_o),
  .cfg_req_valid_o(cfg_req_valid_o), .cfg_req_ready_i(cfg_req_ready_i),
  .cfg_cpl_i(cfg_cpl_i), .cfg_cpl_valid_i(cfg_cpl_valid_i),
  .req_read_hold_o(req_read_hold_o), .cfg_abort_pulse_o(cfg_abort_pulse_o),
  .primary_bus_o(primary_bus_o), .secondary_bus_o(secondary_bus_o),
  .subordinate_bus_o(subordinate_bus_o)
);

// ===== bench/pcera_link_model.sv
// Link and local header model facing the configuration bridge.
// Assumes the bridge holds a request until ready; fail_i spoils the next completion.
`timescale 1ns/1ns
module pcera_link_model
  import pcera_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Requests and completions.
  input pcera_cfg_req_t   cfg_req_i,
  input wire logic        cfg_req_valid_i,
  output logic            cfg_req_ready_o,
  output pcera_cfg_cpl_t  cfg_cpl_o,
  output logic            cfg_cpl_valid_o,
  input wire logic        fail_i,
  // Local header.
  input wire logic        local_en_i,
  input wire logic        local_we_i,
  input wire logic [9:0]  local_index_i,
  input wire logic [3:0]  local_be_i,
  input wire logic [31:0] local_wdata_i,
  output logic [31:0]     local_rdata_o,
  // Observation for the bench.
  output pcera_cfg_req_t  last_req_o,
  output int              req_count_o
);
  logic [31:0] mem [1024];
  logic [1:0]  state_q;
  logic [2:0]  wait_q;
  logic        en_q;

  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 32'h5a00_0000 | 32'(i * 3);
  end

  // Data is only good while enabled and one cycle after; otherwise it shows the inverse.
  assign local_rdata_o = (local_en_i || en_q) ? mem[local_index_i] : ~mem[local_index_i];

  // The wait before ready and before completion varies, so both prompt and slow answers occur.
  always @(posedge clk_i)
  begin
    en_q <= local_en_i;
    cfg_req_ready_o <= 1'b0;
    cfg_cpl_valid_o <= 1'b0;
    cfg_cpl_o.data <= ~cfg_cpl_o.data;
    for (int b = 0; b < 4; b++)
      if (local_en_i && local_we_i && local_be_i[b])
        mem[local_index_i][8*b +: 8] <= local_wdata_i[8*b +: 8];
    if (!rst_n_i)
    begin
      state_q <= 2'h0;
      req_count_o <= 0;
      cfg_cpl_o <= '0;
    end
    else if (state_q == 2'h0 && cfg_req_valid_i)
    begin
      wait_q <= 3'(req_count_o);
      state_q <= 2'h1;
    end
    else if (state_q == 2'h1 && wait_q == 3'h0)
    begin
      cfg_req_ready_o <= 1'b1;
      last_req_o <= cfg_req_i;
      req_count_o <= req_count_o + 1;
      wait_q <= 3'(req_count_o * 5) | 3'h1;
      state_q <= 2'h2;
    end
    else if (state_q == 2'h2 && wait_q == 3'h0)
    begin
      cfg_cpl_valid_o <= 1'b1;
      cfg_cpl_o <= '{ok: !fail_i, data: {6'h15, last_req_o.addr}};
      state_q <= 2'h0;
    end
    else if (state_q != 2'h0)
      wait_q <= wait_q - 3'h1;
  end
endmodule // pcera_link_model

// ===== bench/pcera_bridge_tb.sv
// Self-checking bench for the configuration bridge and its link model.
// Assumes the default aperture of 2^28 bytes from address 0, so bus bits are 27:20.
`timescale 1ns/1ns
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end
module pcera_bridge_tb
  import pcera_pkg::*;
();
  logic        clk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready, fail;
  logic        awready, wready, bvalid, arready, rvalid, req_valid, req_ready, cpl_valid;
  logic        lcl_en, lcl_we, hold, abort;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb, lcl_be;
  logic [7:0]  pri, sec, sub, s_bus, u_bus;
  logic [9:0]  lcl_idx;
  logic [31:0] awaddr, wdata, araddr, rdata, lcl_wd, lcl_rd, lfsr_q;
  logic [31:0] shadow [1024];
  pcera_cfg_req_t req, last_req;
  pcera_cfg_cpl_t cpl;
  int          req_count, mismatches, num_checks;

  pcera_bridge u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .cfg_req_o(req), .cfg_req_valid_o(req_valid), .cfg_req_ready_i(req_ready),
    .cfg_cpl_i(cpl), .cfg_cpl_valid_i(cpl_valid), .local_en_o(lcl_en), .local_we_o(lcl_we),
    .local_index_o(lcl_idx), .local_be_o(lcl_be), .local_wdata_o(lcl_wd),
    .local_rdata_i(lcl_rd), .req_read_hold_o(hold), .cfg_abort_pulse_o(abort),
    .primary_bus_o(pri), .secondary_bus_o(sec), .subordinate_bus_o(sub));

  pcera_link_model u_link (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_req_i(req), .cfg_req_valid_i(req_valid),
    .cfg_req_ready_o(req_ready), .cfg_cpl_o(cpl), .cfg_cpl_valid_o(cpl_valid), .fail_i(fail),
    .local_en_i(lcl_en), .local_we_i(lcl_we), .local_index_i(lcl_idx), .local_be_i(lcl_be),
    .local_wdata_i(lcl_wd), .local_rdata_o(lcl_rd), .last_req_o(last_req),
    .req_count_o(req_count));

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  // Primary bus is zero for the whole run.
  function automatic pcera_route_t route_of(input logic [7:0] bus);
    if (bus == 8'h00) return PCERA_ROUTE_LOCAL;
    if (bus == s_bus) return PCERA_ROUTE_TYPE0;
    if (bus > s_bus && bus <= u_bus) return PCERA_ROUTE_TYPE1;
    return PCERA_ROUTE_ERROR;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One host access; the response ready is held back for a random number of cycles.
  task automatic xfer(input logic we, input logic [31:0] a, d, input logic [3:0] s,
                      output logic [31:0] rd, output logic [1:0] rs);
    int   n;
    logic pa, pw;
    n = 0; pa = 1'b1; pw = we;
    if (we) {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, s, 2'b11};
    else {araddr, arvalid} <= {a, 1'b1};
    while ((pa || pw) && n < 200)
    begin
      @(posedge clk_i);
      n++;
      if (pa && (we ? awready : arready) === 1'b1)
      begin
        pa = 1'b0;
        {awvalid, arvalid} <= 2'b00;
      end
      if (pw && wready === 1'b1)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    repeat (rnd() % 3) @(posedge clk_i);
    {bready, rready} <= {we, !we};
    do @(posedge clk_i); while (!((we ? bvalid : rvalid) === 1'b1) && ++n < 200);
    rd = rdata;
    rs = we ? bresp : rresp;
    {bready, rready} <= 2'b00;
    if (n >= 200) `CHK("handshake", 1'b1, 1'b0)
    repeat (3) @(posedge clk_i);
  endtask

  task automatic access(input logic we, input logic [7:0] bus, input logic [19:0] lo,
                        input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd, m;
    logic [1:0]  rs;
    logic        f, aer;
    int          cnt;
    pcera_route_t rt;
    cnt = req_count; rt = route_of(bus); f = (rnd() % 6 == 0);
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    aer = lo[11:2] >= 10'h040 && lo[11:2] <= 10'h04d;
    fail <= f;
    xfer(we, {4'h0, bus, lo}, d, s, rd, rs);
    if (rt == PCERA_ROUTE_LOCAL)
    begin
      `CHK("local resp", RESP_OKAY, rs)
      if (we && !aer) shadow[lo[11:2]] = (shadow[lo[11:2]] & ~m) | (d & m);
      if (!we) `CHK("local data", aer ? 32'h0 : shadow[lo[11:2]], rd)
    end
    else if (rt == PCERA_ROUTE_ERROR)
    begin
      `CHK("error resp", RESP_SLVERR, rs)
      `CHK("no request", cnt, req_count)
    end
    else
    begin
      `CHK("one request", cnt + 1, req_count)
      `CHK("remote resp", f ? RESP_SLVERR : RESP_OKAY, rs)
      `CHK("fields", {bus, lo[19:2]}, last_req.addr)
      `CHK("type1", rt == PCERA_ROUTE_TYPE1, last_req.cfg_type1)
      `CHK("byte en", we ? s : 4'hf, last_req.byte_en)
      if (we) `CHK("wdata", d, last_req.data)
      if (!we && !f) `CHK("rdata", {6'h15, bus, lo[19:2]}, rd)
    end
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    $display("MISMATCH watchdog expected done seen timeout");
    test_done();
  end

  initial
  begin
    logic [31:0] r, t;
    logic [19:0] lo;
    logic [7:0]  b;
    logic [7:0]  cb [7];
    lfsr_q = 32'h0001_6364;
    {rst_n_i, awvalid, wvalid, bready, arvalid, rready, fail} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {s_bus, u_bus, mismatches, num_checks} = '0;
    for (int i = 0; i < 1024; i++)
      shadow[i] = 32'h5a00_0000 | 32'(i * 3);
    repeat (6) @(posedge clk_i);
    for (int mp = 0; mp < 2; mp++)
    begin
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK("bus map reset", 24'h0, {pri, sec, sub})
      s_bus = mp ? 8'h02 : 8'h01;
      u_bus = mp ? 8'h20 : 8'h05;
      access(1'b1, 8'h00, 20'h00018, {8'h00, u_bus, s_bus, 8'h00}, 4'h7);
      `CHK("bus map", {8'h00, s_bus, u_bus}, {pri, sec, sub})
      cb = '{8'h00, 8'h01, s_bus, s_bus + 8'h1, u_bus, u_bus + 8'h1, 8'hff};
      foreach (cb[i])
      begin
        access(1'b0, cb[i], 20'h0a00c, 32'h0, 4'h0);
        access(1'b1, cb[i], 20'h7e3f1, rnd(), 4'h5);
      end
      access(1'b1, 8'h00, 20'h00104, 32'hffff_ffff, 4'hf);
      access(1'b0, 8'h00, 20'hfd104, 32'h0, 4'h0);
      access(1'b0, 8'h00, 20'h00134, 32'h0, 4'h0);
      repeat (40)
      begin
        r = rnd();
        t = rnd();
        lo = t[19:0];
        b = (r[2:0] == 3'h0) ? 8'h00 : 8'(r[10:3] % (u_bus + 8'h3));
        if (b == 8'h00 && lo[11:2] == 10'h006) lo[8] = 1'b1;
        access(r[31], b, lo, rnd(), r[15:12]);
      end
      $display("map %0d done, checks %0d", mp, num_checks);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    test_done();
  end
endmodule // pcera_bridge_tb
